// *** hmd_regs.sv ***
// host register block: drop counter and indirect mac register access
//
// The address-and-strobe port was decided locally.
`include "hmd_cfg.svh"
`default_nettype none
module hmd_regs
  import hmd_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // host register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // mac frame drop event, same clock
  input wire logic frame_drop_i,
  // mac internal register file port
  output logic mac_req_o,
  output logic mac_wr_o,
  output logic [7:0] mac_idx_o,
  output logic [31:0] mac_wdata_o,
  input wire logic mac_ack_i,
  input wire logic [31:0] mac_rdata_i,
  // half-full pulse toward the interrupt status register
  output logic drop_count_half_irq_o
);
  // bundled request
  hmd_bus_req_t bus;
  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // all state of this module
  typedef struct packed {
    hmd_state_t state;
    logic dir;
    logic [7:0] idx;
    logic [31:0] data;
    logic [31:0] rdata;
    hmd_mac_req_t mac;
    logic irq;
  } hmd_st_t;
  hmd_st_t st_reg;
  hmd_st_t st_next;

  // counter outputs and clear input
  logic [31:0] drop_count;
  logic drop_half;
  logic drop_clear;

  // address decode, used by both read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // busy is simply "not idle"
  logic busy;
  assign busy = (st_reg.state != HMD_IDLE);

  // any read of the counter clears it
  assign drop_clear = bus.rd && hit(bus.addr, `HMD_OFS_DROP);

  hmd_drop_counter #(
    .WIDTH(32)
  ) u_cnt (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .drop_i(frame_drop_i),
    .clear_i(drop_clear),
    .count_o(drop_count),
    .half_o(drop_half)
  );

  // register access and indirect sequencer
  always_comb begin
    st_next = st_reg;
    st_next.mac.req = 1'b0;
    st_next.irq = drop_half;
    st_next.rdata = 32'h0000_0000;
    // read path, data stands one cycle after the strobe
    if (bus.rd) begin
      if (hit(bus.addr, `HMD_OFS_DROP)) begin
        st_next.rdata = drop_count;
      end else if (hit(bus.addr, `HMD_OFS_CMD)) begin
        st_next.rdata = {busy, st_reg.dir, 22'h0, st_reg.idx};
      end else if (hit(bus.addr, `HMD_OFS_DATA)) begin
        // read mode shows captured mac value, write mode last host value
        st_next.rdata = st_reg.data;
      end else begin
        st_next.rdata = `HMD_UNMAPPED;
      end
    end
    // writes are ignored while busy; a careful host never does this
    if (bus.wr && !busy) begin
      if (hit(bus.addr, `HMD_OFS_CMD)) begin
        st_next.dir = bus.wdata[`HMD_CMD_DIR_BIT];
        st_next.idx = bus.wdata[`HMD_CMD_IDX_MSB:0];
        if (bus.wdata[`HMD_CMD_BUSY_BIT]) begin
          st_next.state = HMD_ISSUE;
        end
      end else if (hit(bus.addr, `HMD_OFS_DATA)) begin
        st_next.data = bus.wdata;
      end
    end
    // sequencer
    case (st_reg.state)
      HMD_IDLE: begin
        // nothing in flight
      end
      HMD_ISSUE: begin
        st_next.mac.req = 1'b1;
        st_next.mac.wr = !st_reg.dir;
        st_next.mac.idx = st_reg.idx;
        st_next.mac.wdata = st_reg.data;
        st_next.state = HMD_WAIT;
      end
      HMD_WAIT: begin
        // busy holds until the mac acknowledges
        if (mac_ack_i) begin
          if (st_reg.dir) begin
            st_next.data = mac_rdata_i;
          end
          st_next.state = HMD_IDLE;
        end
      end
      default: begin
        st_next.state = HMD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg.state <= HMD_IDLE;
      st_reg.dir <= 1'b0;
      st_reg.idx <= `HMD_IDX_RESET;
      st_reg.data <= `HMD_DATA_RESET;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.mac <= '0;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = st_reg.rdata;
  assign mac_req_o = st_reg.mac.req;
  assign mac_wr_o = st_reg.mac.wr;
  assign mac_idx_o = st_reg.mac.idx;
  assign mac_wdata_o = st_reg.mac.wdata;
  assign drop_count_half_irq_o = st_reg.irq;

  // start, issue, finish and command-write sequences of an indirect access
  // a start is a command write with busy set while nothing is in flight
  sequence s_start;
    wr_i && !busy && addr_i == `HMD_OFS_CMD && wdata_i[`HMD_CMD_BUSY_BIT];
  endsequence
  // the request leaves two edges after the start is taken
  sequence s_issue;
    ##2 mac_req_o;
  endsequence
  // the mac answers while the sequencer waits for it
  sequence s_done;
    st_reg.state == HMD_WAIT && mac_ack_i;
  endsequence
  // a host write to the command register while idle
  sequence s_cmd_write;
    wr_i && !busy && addr_i == `HMD_OFS_CMD;
  endsequence

  AST_START_ISSUES: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_start |-> s_issue)
    else $error("start did not issue mac request");
  AST_BUSY_HOLDS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    busy && !mac_ack_i |=> busy)
    else $error("busy dropped before completion");
  AST_READ_CAPTURE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    st_reg.state == HMD_WAIT && mac_ack_i && st_reg.dir
    |=> !busy && st_reg.data == $past(mac_rdata_i))
    else $error("read data not captured at completion");
  AST_WRITE_DIR: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    mac_req_o |-> mac_wr_o == !st_reg.dir && mac_idx_o == st_reg.idx)
    else $error("mac request direction or index wrong");
  AST_WRITE_DATA: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    mac_req_o && mac_wr_o |-> mac_wdata_o == st_reg.data)
    else $error("write data not copied to mac");
  AST_DATA_WRITE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_i && !busy && addr_i == `HMD_OFS_DATA |=> st_reg.data == $past(wdata_i))
    else $error("data register not written");
  AST_DATA_READ: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    rd_i && addr_i == `HMD_OFS_DATA |=> rdata_o == $past(st_reg.data))
    else $error("data read returned wrong value");
  AST_DROP_READ_CLEAR: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    rd_i && addr_i == `HMD_OFS_DROP && !frame_drop_i
    |=> rdata_o == $past(drop_count) && drop_count == 32'h0000_0000)
    else $error("counter read did not return and clear");
  AST_IRQ_FOLLOWS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    drop_half |=> drop_count_half_irq_o)
    else $error("half flag not passed to irq output");
  AST_BUSY_WRITE_IGNORED: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_i && busy && addr_i == `HMD_OFS_CMD |=> st_reg.idx == $past(st_reg.idx))
    else $error("command changed while busy");

  // completion frees the block on the very next edge
  AST_DONE_CLEARS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_done |=> !busy)
    else $error("busy still set after completion");
  // the request is a single pulse, so the mac sees one access per start
  AST_REQ_PULSE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    mac_req_o |=> !mac_req_o)
    else $error("mac request longer than one cycle");
  // a request never leaves while the block claims to be idle
  AST_REQ_ONLY_BUSY: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    mac_req_o |-> busy)
    else $error("mac request while idle");
  // idle stays idle unless a start is written
  AST_IDLE_STAYS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !busy && !(wr_i && addr_i == `HMD_OFS_CMD && wdata_i[`HMD_CMD_BUSY_BIT])
    |=> !busy)
    else $error("busy set without a start");
  // direction loads on any idle command write
  AST_DIR_LOAD: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_cmd_write |=> st_reg.dir == $past(wdata_i[`HMD_CMD_DIR_BIT]))
    else $error("direction bit not loaded");
  // index loads on any idle command write
  AST_IDX_LOAD: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_cmd_write |=> st_reg.idx == $past(wdata_i[`HMD_CMD_IDX_MSB:0]))
    else $error("index field not loaded");
  // command read shows busy, direction and index, reserved bits zero
  AST_CMD_READ: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    rd_i && addr_i == `HMD_OFS_CMD
    |=> rdata_o == {$past(busy), $past(st_reg.dir), 22'h0, $past(st_reg.idx)})
    else $error("command read returned wrong value");
  // a host data write while busy must not disturb the pending value
  AST_DATA_BUSY_KEEP: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    wr_i && busy && addr_i == `HMD_OFS_DATA && !mac_ack_i
    |=> st_reg.data == $past(st_reg.data))
    else $error("data changed while busy");
  // a write access leaves the data register as the host wrote it
  AST_WRITE_KEEPS_DATA: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    s_done ##0 !st_reg.dir |=> st_reg.data == $past(st_reg.data))
    else $error("write access altered the data register");
  // the half-full pulse never lasts two cycles
  AST_IRQ_PULSE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    drop_count_half_irq_o |=> !drop_count_half_irq_o)
    else $error("half-full pulse too long");
  // read data stand for one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data not zero outside a read");
endmodule : hmd_regs
`default_nettype wire

// *** hmd_cfg.svh ***
// constants for the host mac drop counter and indirect access block
// Operation
// - count each frame the mac drops
// - counter read returns count and clears it
// - flag half-full when count crosses midpoint
// - busy write of one starts indirect access
// - busy stays set until operation done
// - busy clear means read data valid
// - direction bit: zero writes, one reads
// - eight-bit index selects mac register
// - data register holds write or read value
// - data read shows mac value when reading
`ifndef HMD_CFG_SVH
`define HMD_CFG_SVH
`define HMD_ADDR_W 8
`define HMD_OFS_DROP 8'ha0
`define HMD_OFS_CMD 8'ha4
`define HMD_OFS_DATA 8'ha8
`define HMD_CMD_BUSY_BIT 31
`define HMD_CMD_DIR_BIT 30
`define HMD_CMD_IDX_MSB 7
`define HMD_DROP_RESET 32'h0000_0000
`define HMD_DATA_RESET 32'h0000_0000
`define HMD_IDX_RESET 8'h00
`define HMD_DROP_MID 32'h7fff_ffff
`define HMD_UNMAPPED 32'h0000_0000
`endif

// *** hmd_pkg.sv ***
// types shared by the host mac drop counter and indirect access block
`default_nettype none
package hmd_pkg;
  // register bus request from the host
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hmd_bus_req_t;
  // indirect access states, one-hot
  typedef enum logic [2:0] {
    HMD_IDLE = 3'b001,
    HMD_ISSUE = 3'b010,
    HMD_WAIT = 3'b100
  } hmd_state_t;
  // request toward the mac register file
  typedef struct packed {
    logic req;
    logic wr;
    logic [7:0] idx;
    logic [31:0] wdata;
  } hmd_mac_req_t;
endpackage : hmd_pkg
`default_nettype wire

// *** hmd_drop_counter.sv ***
// read-clear dropped frame counter with midpoint crossing pulse
`include "hmd_cfg.svh"
`default_nettype none
module hmd_drop_counter
  import hmd_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // events
  input wire logic drop_i,
  input wire logic clear_i,
  // state out
  output logic [WIDTH-1:0] count_o,
  output logic half_o
);
  // all state of this module
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic half;
  } hmd_cnt_st_t;
  hmd_cnt_st_t st_reg;
  hmd_cnt_st_t st_next;

  // a drop landing in the clearing cycle counts as one, so it is not lost
  always_comb begin
    st_next = st_reg;
    st_next.half = 1'b0;
    if (clear_i) begin
      st_next.cnt = WIDTH'(drop_i);
    end else if (drop_i) begin
      st_next.cnt = st_reg.cnt + WIDTH'(1);
      // midpoint crossing seen on the increment itself
      st_next.half = (st_reg.cnt == WIDTH'(`HMD_DROP_MID));
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign count_o = st_reg.cnt;
  assign half_o = st_reg.half;

  AST_DROP_INC: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    drop_i && !clear_i |=> count_o == $past(count_o) + WIDTH'(1))
    else $error("drop did not increment count");
  AST_HALF_CROSS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    half_o |-> count_o == WIDTH'(`HMD_DROP_MID) + WIDTH'(1))
    else $error("half flag without midpoint crossing");
endmodule : hmd_drop_counter
`default_nettype wire

// *** hmd_mac_model.sv ***
// behavioural model of the mac internal register file
`default_nettype none
module hmd_mac_model (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_n_i,
  // request from the register block
  input wire logic mac_req_i,
  input wire logic mac_wr_i,
  input wire logic [7:0] mac_idx_i,
  input wire logic [31:0] mac_wdata_i,
  // answer back
  output logic mac_ack_o,
  output logic [31:0] mac_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [256]; // register file, starts cleared
  logic [1:0] dly; // varies the answer time so slow and quick acks occur
  int wait_n; // cycles left before the ack
  initial begin
    foreach (mem[k]) mem[k] = 32'h0;
  end
  // answer each request three to six cycles after it rises
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mac_ack_o <= 1'b0;
      mac_rdata_o <= 32'h0;
      wait_n <= 0;
      dly <= 2'h0;
    end else begin
      mac_ack_o <= 1'b0;
      // read data is only good with the ack, so scramble it meanwhile
      mac_rdata_o <= ~mac_rdata_o;
      if (mac_req_i) begin
        wait_n <= 2 + int'(dly);
        dly <= dly + 2'h1;
      end else if (wait_n == 1) begin
        // fields are held by the block after the request
        mac_ack_o <= 1'b1;
        if (mac_wr_i) mem[mac_idx_i] <= mac_wdata_i;
        else mac_rdata_o <= mem[mac_idx_i];
        wait_n <= 0;
      end else if (wait_n > 1) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule : hmd_mac_model
`default_nettype wire

// *** test_hmd_regs.sv ***
// testbench for the host drop counter and indirect access registers
`default_nettype none
module test_hmd_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, reset_n_i, wr, rd, drop, rd_d, ack_seen;
  logic mreq, mwr, mack, exp_wr, irq;
  logic [7:0] addr, midx, exp_idx;
  logic [31:0] wd, rdata, mwd, mrd, exp_wd;
  logic [31:0] exp_q [$]; // expected read data, oldest first
  int failures, num_checks, seed;
  hmd_regs i_hmd_regs (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .frame_drop_i(drop), .mac_req_o(mreq), .mac_wr_o(mwr),
    .mac_idx_o(midx), .mac_wdata_o(mwd), .mac_ack_i(mack),
    .mac_rdata_i(mrd), .drop_count_half_irq_o(irq));
  hmd_mac_model i_hmd_mac_model (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .mac_req_i(mreq), .mac_wr_i(mwr), .mac_idx_i(midx),
    .mac_wdata_i(mwd), .mac_ack_o(mack), .mac_rdata_o(mrd));
  // free running clock
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task automatic check(input string what, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // one bus cycle; for a read d is the expected data
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    @(posedge clock_i);
    addr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock_i);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // indirect access: start, see busy, wait for the mac, read back
  task automatic op(input logic dir, input logic [7:0] idx,
                    input logic [31:0] d);
    int n;
    exp_wr = !dir;
    exp_idx = idx;
    exp_wd = d;
    ack_seen = 1'b0;
    bus(1'b1, 8'ha4, {1'b1, dir, 22'h0, idx});
    bus(1'b0, 8'ha4, {1'b1, dir, 22'h0, idx});
    for (n = 0; n < 20 && ack_seen !== 1'b1; n++) @(posedge clock_i);
    check("mac_ack", {31'h0, ack_seen}, 32'h1);
    bus(1'b0, 8'ha4, {1'b0, dir, 22'h0, idx});
    bus(1'b0, 8'ha8, d);
  endtask : op
  // results are settled by the falling edge
  always @(posedge clock_i) rd_d <= rd;
  always @(negedge clock_i) begin
    if (rd_d === 1'b1) check("rdata_o", rdata, exp_q.pop_front());
    if (mack === 1'b1) ack_seen = 1'b1;
    check("irq", {31'h0, irq}, 32'h0);
    if (mreq === 1'b1) begin
      check("mac_wr_o", {31'h0, mwr}, {31'h0, exp_wr});
      check("mac_idx_o", {24'h0, midx}, {24'h0, exp_idx});
      if (exp_wr) check("mac_wdata_o", mwd, exp_wd);
    end
  end
  // main sequence
  initial begin
    int i, n;
    logic [7:0] idx;
    logic [31:0] d;
    seed = 10719;
    failures = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    {wr, rd, drop, addr, wd} = '0;
    repeat (10) @(posedge clock_i);
    reset_n_i <= 1'b1;
    bus(1'b0, 8'ha0, 32'h0);
    bus(1'b0, 8'ha4, 32'h0);
    bus(1'b0, 8'ha8, 32'h0);
    bus(1'b0, 8'hbc, 32'h0); // unmapped place reads zero
    for (i = 0; i < 4; i++) begin
      n = ($random(seed) & 7) + 1;
      repeat (n) begin
        @(posedge clock_i);
        drop <= 1'b1;
      end
      @(posedge clock_i);
      drop <= 1'b0;
      bus(1'b0, 8'ha0, 32'(n));
      bus(1'b0, 8'ha0, 32'h0);
      idx = 8'($random(seed));
      d = $random(seed);
      bus(1'b1, 8'ha8, d);
      op(1'b0, idx, d); // write mode shows the host value
      op(1'b1, idx, d); // read mode shows the mac value
    end
    repeat (5) @(posedge clock_i);
    print_verdict();
  end
  // the tests take well under a thousand cycles
  initial begin
    #100000;
    failures++;
    print_verdict();
  end
endmodule : test_hmd_regs
`default_nettype wire
